/* rtl/fwp_top.sv */
// What this block does
// - Link messages are 16 bits wide and their bit meaning is set by the sender.
// - The raw source delivers the held message unchanged with no shift, mask or offset.
// - The register-forward source gives ((last forwarded word >> shift) & mask) + offset, shift 0-15, mask 16 bits, offset 0-1023.
// - The decoder source gives ((last decoder word >> shift) & mask) + offset, shift 0-7, mask 8 bits, offset 0-1023.
// - Each processed source has its own chain and settings, and writing one never touches the other; the raw source has neither.
// - Every consuming operation picks its source through its selector, and both branch and table play accept all sources.
// - The processed value serves either as a branch value or as a command table index.
// - Shift, mask and offset may be rewritten at run time between operations.
// - The settings live in this sequencer's own registers, so it extracts only its own subset.
// - An unconfigured processed path passes its own last message through unchanged; the raw path passes the last message of either kind.
`timescale 1ns/1ps
`default_nettype none
`include "fwp_map.svh"

module fwp_top
   import fwp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic link_valid,
   input wire fwp_kind_e link_kind,
   input wire logic [15:0] link_word,
   input wire fwp_req_s branch_req,
   output logic branch_valid,
   output logic [16:0] branch_value,
   input wire fwp_req_s play_req,
   output logic play_valid,
   output logic [16:0] play_index,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata
);

   // ----------------------------------------
   // configuration group
   // ----------------------------------------
   fwp_cfg_s reg_cfg;
   fwp_cfg_s dec_cfg;
   logic reg_on;
   logic dec_on;
   fwp_cfg_s next_reg_cfg;
   fwp_cfg_s next_dec_cfg;
   logic next_reg_on;
   logic next_dec_on;

   always_comb begin
      next_reg_cfg = reg_cfg;
      next_dec_cfg = dec_cfg;
      next_reg_on = reg_on;
      next_dec_on = dec_on;
      if (reg_write) begin
         case (reg_addr)
            `FWP_REG_SHIFT_OFS: begin
               next_reg_cfg.shift = reg_wdata[3:0];
               next_reg_on = 1'b1;
            end
            `FWP_REG_MASK_OFS: begin
               next_reg_cfg.mask = reg_wdata[15:0];
               next_reg_on = 1'b1;
            end
            `FWP_REG_OFFSET_OFS: begin
               next_reg_cfg.offset = reg_wdata[9:0];
               next_reg_on = 1'b1;
            end
            `FWP_DEC_SHIFT_OFS: begin
               next_dec_cfg.shift = {1'b0, reg_wdata[2:0]};
               next_dec_on = 1'b1;
            end
            `FWP_DEC_MASK_OFS: begin
               next_dec_cfg.mask = {8'h00, reg_wdata[7:0]};
               next_dec_on = 1'b1;
            end
            `FWP_DEC_OFFSET_OFS: begin
               next_dec_cfg.offset = reg_wdata[9:0];
               next_dec_on = 1'b1;
            end
            `FWP_STATUS_OFS: begin
               // writing zero returns a path to pass-through
               next_reg_on = reg_wdata[`FWP_ST_REG_ON_BIT];
               next_dec_on = reg_wdata[`FWP_ST_DEC_ON_BIT];
            end
            default: begin
               next_reg_on = reg_on;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_cfg <= '{`FWP_SHIFT_RST, `FWP_MASK_RST, `FWP_OFFSET_RST};
         dec_cfg <= '{`FWP_SHIFT_RST, `FWP_MASK_RST, `FWP_OFFSET_RST};
         reg_on <= 1'b0;
         dec_on <= 1'b0;
      end else begin
         reg_cfg <= next_reg_cfg;
         dec_cfg <= next_dec_cfg;
         reg_on <= next_reg_on;
         dec_on <= next_dec_on;
      end
   end

   // ----------------------------------------
   // link message hold group
   // ----------------------------------------
   logic [15:0] raw_word;
   logic [15:0] reg_word;
   logic [15:0] dec_word;
   logic [15:0] msg_count;
   logic [15:0] next_raw_word;
   logic [15:0] next_reg_word;
   logic [15:0] next_dec_word;
   logic [15:0] next_msg_count;

   always_comb begin
      next_raw_word = raw_word;
      next_reg_word = reg_word;
      next_dec_word = dec_word;
      next_msg_count = msg_count;
      if (link_valid) begin
         next_raw_word = link_word;
         next_msg_count = msg_count + 16'h0001;
         if (link_kind == FWP_KIND_DEC) begin
            next_dec_word = link_word;
         end else begin
            next_reg_word = link_word;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         raw_word <= `FWP_WORD_RST;
         reg_word <= `FWP_WORD_RST;
         dec_word <= `FWP_WORD_RST;
         msg_count <= `FWP_COUNT_RST;
      end else begin
         raw_word <= next_raw_word;
         reg_word <= next_reg_word;
         dec_word <= next_dec_word;
         msg_count <= next_msg_count;
      end
   end

   // ----------------------------------------
   // processing chains
   // ----------------------------------------
   logic [16:0] reg_result;
   logic [16:0] dec_result;

   // separate chain per processed source; raw has none
   fwp_chain #(.SHIFT_W(4), .MASK_W(16)) u_reg_chain (
      .word(reg_word),
      .cfg(reg_cfg),
      .configured(reg_on),
      .result(reg_result)
   );

   fwp_chain #(.SHIFT_W(3), .MASK_W(8)) u_dec_chain (
      .word(dec_word),
      .cfg(dec_cfg),
      .configured(dec_on),
      .result(dec_result)
   );

   // ----------------------------------------
   // answer group
   // ----------------------------------------
   logic [16:0] branch_pick;
   logic [16:0] play_pick;
   logic next_branch_valid;
   logic next_play_valid;
   logic [16:0] next_branch_value;
   logic [16:0] next_play_index;

   always_comb begin
      case (branch_req.src)
         FWP_SRC_RAW: branch_pick = {1'b0, raw_word};
         FWP_SRC_REG: branch_pick = reg_result;
         FWP_SRC_DEC: branch_pick = dec_result;
         default: branch_pick = `FWP_VALUE_RST;
      endcase
      case (play_req.src)
         FWP_SRC_RAW: play_pick = {1'b0, raw_word};
         FWP_SRC_REG: play_pick = reg_result;
         FWP_SRC_DEC: play_pick = dec_result;
         default: play_pick = `FWP_VALUE_RST;
      endcase
      next_branch_valid = branch_req.req;
      next_play_valid = play_req.req;
      next_branch_value = branch_req.req ? branch_pick : branch_value;
      next_play_index = play_req.req ? play_pick : play_index;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         branch_valid <= 1'b0;
         play_valid <= 1'b0;
         branch_value <= `FWP_VALUE_RST;
         play_index <= `FWP_VALUE_RST;
      end else begin
         branch_valid <= next_branch_valid;
         play_valid <= next_play_valid;
         branch_value <= next_branch_value;
         play_index <= next_play_index;
      end
   end

   // ----------------------------------------
   // register read group
   // ----------------------------------------
   logic [31:0] rd_val;
   logic [31:0] next_reg_rdata;

   always_comb begin
      case (reg_addr)
         `FWP_REG_SHIFT_OFS: rd_val = 32'(reg_cfg.shift);
         `FWP_REG_MASK_OFS: rd_val = 32'(reg_cfg.mask);
         `FWP_REG_OFFSET_OFS: rd_val = 32'(reg_cfg.offset);
         `FWP_DEC_SHIFT_OFS: rd_val = 32'(dec_cfg.shift);
         `FWP_DEC_MASK_OFS: rd_val = 32'(dec_cfg.mask);
         `FWP_DEC_OFFSET_OFS: rd_val = 32'(dec_cfg.offset);
         `FWP_STATUS_OFS: rd_val = 32'({dec_on, reg_on});
         `FWP_LAST_RAW_OFS: rd_val = 32'(raw_word);
         `FWP_LAST_REG_OFS: rd_val = 32'(reg_word);
         `FWP_LAST_DEC_OFS: rd_val = 32'(dec_word);
         `FWP_MSG_COUNT_OFS: rd_val = 32'(msg_count);
         default: rd_val = `FWP_RDATA_RST;
      endcase
      next_reg_rdata = reg_read ? rd_val : `FWP_RDATA_RST;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= `FWP_RDATA_RST;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   hold_word_a: assert property (
      @(posedge clk) disable iff (reset)
      link_valid |=> raw_word == $past(link_word)
   ) else $error("held link word does not match last message");

   raw_path_a: assert property (
      @(posedge clk) disable iff (reset)
      (branch_req.req && branch_req.src == FWP_SRC_RAW)
         |=> branch_value == {1'b0, $past(raw_word)}
   ) else $error("raw branch value altered");

   reg_path_a: assert property (
      @(posedge clk) disable iff (reset)
      (play_req.req && play_req.src == FWP_SRC_REG && reg_on)
         |=> play_index == {1'b0, ($past(reg_word) >> $past(reg_cfg.shift))
            & $past(reg_cfg.mask)} + {7'h00, $past(reg_cfg.offset)}
   ) else $error("register-forward result wrong");

   dec_path_a: assert property (
      @(posedge clk) disable iff (reset)
      (branch_req.req && branch_req.src == FWP_SRC_DEC && dec_on)
         |=> branch_value == {9'h000, 8'(($past(dec_word) >> $past(dec_cfg.shift[2:0]))
            & $past(dec_cfg.mask))} + {7'h00, $past(dec_cfg.offset)}
   ) else $error("decoder result wrong");

   chain_apart_a: assert property (
      @(posedge clk) disable iff (reset)
      (reg_write && reg_addr inside {`FWP_REG_SHIFT_OFS, `FWP_REG_MASK_OFS,
         `FWP_REG_OFFSET_OFS}) |=> $stable(dec_cfg) && $stable(dec_on)
   ) else $error("decoder settings disturbed by register-forward write");

   answer_timing_a: assert property (
      @(posedge clk) disable iff (reset)
      (play_req.req && play_req.src == FWP_SRC_RAW)
         |=> play_valid && play_index == {1'b0, $past(raw_word)}
   ) else $error("table play answer not raw word one cycle after request");

   live_update_a: assert property (
      @(posedge clk) disable iff (reset)
      (reg_write && reg_addr == `FWP_DEC_SHIFT_OFS)
         |=> dec_on && dec_cfg.shift == {1'b0, $past(reg_wdata[2:0])}
   ) else $error("decoder shift not updated at run time");

   pass_through_a: assert property (
      @(posedge clk) disable iff (reset)
      (play_req.req && play_req.src == FWP_SRC_REG && !reg_on)
         |=> play_index == {1'b0, $past(reg_word)}
   ) else $error("unconfigured path not passing through");

   no_overflow_a: assert property (
      @(posedge clk) disable iff (reset)
      play_valid |-> play_index <= 17'h1_03fe
   ) else $error("table index above largest sum");

endmodule

`default_nettype wire

/* rtl/fwp_map.svh */
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FWP_REG_SHIFT_OFS 8'h00
`define FWP_REG_MASK_OFS 8'h04
`define FWP_REG_OFFSET_OFS 8'h08
`define FWP_DEC_SHIFT_OFS 8'h0c
`define FWP_DEC_MASK_OFS 8'h10
`define FWP_DEC_OFFSET_OFS 8'h14
`define FWP_STATUS_OFS 8'h18
`define FWP_LAST_RAW_OFS 8'h1c
`define FWP_LAST_REG_OFS 8'h20
`define FWP_LAST_DEC_OFS 8'h24
`define FWP_MSG_COUNT_OFS 8'h28

// ----------------------------------------
// status field positions
// ----------------------------------------
`define FWP_ST_REG_ON_BIT 0
`define FWP_ST_DEC_ON_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define FWP_SHIFT_RST 4'h0
`define FWP_MASK_RST 16'hffff
`define FWP_OFFSET_RST 10'h000
`define FWP_WORD_RST 16'h0000
`define FWP_COUNT_RST 16'h0000
`define FWP_VALUE_RST 17'h0_0000
`define FWP_RDATA_RST 32'h0000_0000

`endif

/* rtl/fwp_pkg.sv */
package fwp_pkg;

   // ----------------------------------------
   // feedback source selector
   // ----------------------------------------
   typedef enum logic [1:0] {
      FWP_SRC_RAW = 2'b00,
      FWP_SRC_REG = 2'b01,
      FWP_SRC_DEC = 2'b10
   } fwp_src_e;

   // kind of message arriving on the link
   typedef enum logic [0:0] {
      FWP_KIND_REG = 1'b0,
      FWP_KIND_DEC = 1'b1
   } fwp_kind_e;

   // processing settings of one chain
   typedef struct packed {
      logic [3:0] shift;
      logic [15:0] mask;
      logic [9:0] offset;
   } fwp_cfg_s;

   // request from a feedback-consuming operation
   typedef struct packed {
      logic req;
      fwp_src_e src;
   } fwp_req_s;

endpackage

/* rtl/fwp_chain.sv */
`timescale 1ns/1ps
`default_nettype none

module fwp_chain
   import fwp_pkg::*;
#(
   parameter int SHIFT_W = 4,
   parameter int MASK_W = 16
) (
   input wire logic [15:0] word,
   input wire fwp_cfg_s cfg,
   input wire logic configured,
   output logic [16:0] result
);

   localparam logic [3:0] SHIFT_LIM = 4'((5'd1 << SHIFT_W) - 5'd1);
   localparam logic [15:0] MASK_LIM = 16'((17'd1 << MASK_W) - 17'd1);

   logic [15:0] shifted;
   logic [15:0] masked;

   always_comb begin
      shifted = word >> (cfg.shift & SHIFT_LIM);
      masked = shifted & (cfg.mask & MASK_LIM);
      // 17 bits hold mask max plus offset max
      if (configured) begin
         result = {1'b0, masked} + {7'h00, cfg.offset};
      end else begin
         result = {1'b0, word};
      end
   end

endmodule

`default_nettype wire

/* verif/fwp_link_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// far-side feedback controller
// ----------------------------------------
module fwp_link_model
   import fwp_pkg::*;
(
   input wire logic clk,
   output logic link_valid,
   output fwp_kind_e link_kind,
   output logic [15:0] link_word
);
   initial begin
      link_valid = 1'b0;
      link_kind = FWP_KIND_REG;
      link_word = 16'h0000;
   end

   // one 16-bit word per one-cycle strobe
   task automatic send(input fwp_kind_e kind, input logic [15:0] word);
      @(posedge clk);
      link_valid <= 1'b1;
      link_kind <= kind;
      link_word <= word;
      @(posedge clk);
      link_valid <= 1'b0;
      // released lines show junk, not the last word
      link_kind <= fwp_kind_e'(~kind);
      link_word <= ~word;
   endtask
endmodule

`default_nettype wire

/* verif/fwp_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module fwp_top_bench
   import fwp_pkg::*;
;
   typedef struct packed {
      fwp_kind_e kind;
      logic [15:0] word;
      logic [1:0] bsrc;
      logic [1:0] psrc;
      logic [16:0] bexp;
      logic [16:0] pexp;
   } fwp_row_s;

   logic clk;
   logic reset;
   logic link_valid;
   fwp_kind_e link_kind;
   logic [15:0] link_word;
   fwp_req_s branch_req;
   fwp_req_s play_req;
   logic branch_valid;
   logic play_valid;
   logic [16:0] branch_value;
   logic [16:0] play_index;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [31:0] reg_rdata;
   logic [31:0] d;
   logic [16:0] bv;
   logic [16:0] pv;
   int num_errors = 0;
   int num_checks = 0;
   fwp_row_s rows [0:3] = '{
      '{FWP_KIND_REG, 16'h1234, 2'b01, 2'b00, 17'h0_0422, 17'h0_1234},
      '{FWP_KIND_DEC, 16'h00f8, 2'b01, 2'b10, 17'h0_0422, 17'h0_0016},
      '{FWP_KIND_REG, 16'hffff, 2'b01, 2'b11, 17'h0_04fe, 17'h0_0000},
      '{FWP_KIND_DEC, 16'hffff, 2'b10, 2'b00, 17'h0_0016, 17'h0_ffff}};

   always #10 clk = ~clk;

   fwp_link_model fwp_link_model_inst (
      .clk(clk), .link_valid(link_valid), .link_kind(link_kind), .link_word(link_word));

   fwp_top fwp_top_inst (
      .clk(clk), .reset(reset), .link_valid(link_valid), .link_kind(link_kind),
      .link_word(link_word), .branch_req(branch_req), .branch_valid(branch_valid),
      .branch_value(branch_value), .play_req(play_req), .play_valid(play_valid),
      .play_index(play_index), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

   // ----------------------------------------
   // compare, bus and request tasks
   // ----------------------------------------
   task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   // both requests at once; both valids must be high, then play_valid low and play_index held
   task automatic request(input logic [1:0] bs, input logic [1:0] ps,
                          output logic [16:0] b, output logic [16:0] p);
      @(posedge clk);
      branch_req <= '{req: 1'b1, src: fwp_src_e'(bs)};
      play_req <= '{req: 1'b1, src: fwp_src_e'(ps)};
      @(posedge clk);
      branch_req.req <= 1'b0;
      play_req.req <= 1'b0;
      #1;
      chk_bit("branch_valid", 1'b1, branch_valid);
      chk_bit("play_valid", 1'b1, play_valid);
      b = branch_value;
      p = play_index;
      @(posedge clk);
      #1;
      chk_bit("play_valid_end", 1'b0, play_valid);
      chk_val("play_index_hold", {15'h0000, p}, {15'h0000, play_index});
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("ERROR run_time expected end seen timeout");
      finish_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      branch_req = '0;
      play_req = '0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk_val("branch_value_rst", 32'h0000_0000, {15'h0000, branch_value});
      reg_rd(8'h04, d);
      chk_val("mask_rst", 32'h0000_ffff, d);
      reg_rd(8'h18, d);
      chk_val("status_rst", 32'h0000_0000, d);
      fwp_link_model_inst.send(FWP_KIND_REG, 16'habcd);
      request(2'b01, 2'b10, bv, pv);
      chk_val("unconfigured_reg", 32'h0000_abcd, {15'h0000, bv});
      chk_val("unconfigured_dec", 32'h0000_0000, {15'h0000, pv});
      reg_wr(8'h00, 32'h0000_0004);
      reg_wr(8'h04, 32'h0000_00ff);
      reg_wr(8'h08, 32'h0000_03ff);
      reg_wr(8'h0c, 32'h0000_0003);
      reg_wr(8'h10, 32'h0000_000f);
      reg_wr(8'h14, 32'h0000_0007);
      reg_rd(8'h18, d);
      chk_val("status_set", 32'h0000_0003, d);
      for (int i = 0; i < 4; i++) begin
         fwp_link_model_inst.send(rows[i].kind, rows[i].word);
         request(rows[i].bsrc, rows[i].psrc, bv, pv);
         chk_val("branch_value", {15'h0000, rows[i].bexp}, {15'h0000, bv});
         chk_val("play_index", {15'h0000, rows[i].pexp}, {15'h0000, pv});
      end
      reg_wr(8'h0c, 32'h0000_000f);
      reg_rd(8'h0c, d);
      chk_val("dec_shift_limit", 32'h0000_0007, d);
      reg_wr(8'h04, 32'h0000_0001);
      request(2'b01, 2'b00, bv, pv);
      chk_val("mask_rewrite", 32'h0000_0400, {15'h0000, bv});
      chk_val("raw_last_any", 32'h0000_ffff, {15'h0000, pv});
      request(2'b00, 2'b01, bv, pv);
      chk_val("raw_branch", 32'h0000_ffff, {15'h0000, bv});
      chk_val("play_reg", 32'h0000_0400, {15'h0000, pv});
      reg_wr(8'h18, 32'h0000_0002);
      request(2'b01, 2'b10, bv, pv);
      chk_val("status_clear", 32'h0000_ffff, {15'h0000, bv});
      chk_val("dec_untouched", 32'h0000_0016, {15'h0000, pv});
      request(2'b00, 2'b01, bv, pv);
      chk_val("raw_branch_2", 32'h0000_ffff, {15'h0000, bv});
      chk_val("unconfigured_play", 32'h0000_ffff, {15'h0000, pv});
      reg_rd(8'h20, d);
      chk_val("last_reg_word", 32'h0000_ffff, d);
      reg_rd(8'h28, d);
      chk_val("msg_count", 32'h0000_0005, d);
      reg_rd(8'h40, d);
      chk_val("unmapped_read", 32'h0000_0000, d);
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      #1;
      chk_val("play_index_rst", 32'h0000_0000, {15'h0000, play_index});
      reg_rd(8'h18, d);
      chk_val("status_rst2", 32'h0000_0000, d);
      finish_test();
   end
endmodule

`default_nettype wire
